// file: core/cpu_state.v
// Programmer-visible core state: accumulator, index pair, stack pointer, program
// counter, status word, plus the vector fetch engine of the program-memory map.
// Assumes one sequencer on clk issues at most one state operation per cycle and
// that program memory returns a byte one cycle after rom_addr_q changes.
`include "cpu_state_defines.vh"
`timescale 1ns/1ps
`default_nettype none

// Operation
// (RL1) Reset loads counter from top vector
// (RL2) Stack in 100h-17Fh, not reset
// (RL3) Calls and interrupts move the stack pointer
// (RL4) Accumulator pairs with second index register
// (RL5) Index adds to address; inc/dec/compare/move
// (RL6) Carry from ALU, shifts and rotates
// (RL7) Zero flag follows zero result
// (RL8) Enable flag gates all but reset/break
// (RL9) Service clears enable; instructions set/clear
// (RL10) Half carry sticky until clear-overflow
// (RL11) Break sets break flag
// (RL12) Overflow sticky; bit-test copies bit 6
// (RL13) Negative follows bit 7; bit-test bit 7
// (RL14) Page flag picks direct page 0/1
// (RL15) Program memory 16K read-only of 64K
// (RL16) Fetches beyond 16K wrap to zero
// (RL17) Table call entries below FFC0h downward; the code places them from FFDEh down to FFC0h
// (RL18) Page call reaches page area short
// (RL19) Interrupt vectors at FFE0h onward
// (RL20) Unused vectors usable as program memory
// (RL21) Flags held in one pushable byte
module cpu_state (
  // Clock and reset
  input  wire        clk,
  input  wire        nrst,
  // Program memory read port
  input  wire [7:0]  rom_data,
  output reg  [15:0] rom_addr_q,
  output reg         vec_busy_q,
  // Register loads and transfers
  input  wire        acc_load,
  input  wire [7:0]  acc_din,
  input  wire        pair_load,
  input  wire [15:0] pair_din,
  input  wire [2:0]  idx_op,
  input  wire        idx_sel,
  input  wire [7:0]  idx_din,
  // ALU and bit test
  input  wire [2:0]  alu_op,
  input  wire [7:0]  alu_operand,
  input  wire        bit_test,
  // Flag instructions and status word restore
  input  wire        enable_interrupts_instr,
  input  wire        disable_interrupts_instr,
  input  wire        clear_overflow_instr,
  input  wire        clear_page_instr,
  input  wire        set_page_instr,
  input  wire        status_load,
  input  wire [7:0]  status_din,
  // Flow control
  input  wire        pc_inc,
  input  wire        pc_load,
  input  wire [15:0] pc_din,
  input  wire        call,
  input  wire        ret,
  input  wire        ret_int,
  input  wire        stack_ptr_load,
  input  wire        table_call,
  input  wire [3:0]  table_index,
  input  wire        page_call,
  input  wire [7:0]  page_offset,
  input  wire        software_break,
  input  wire        irq_pending,
  input  wire        int_accept,
  input  wire [3:0]  int_src,
  // Effective address unit
  input  wire [1:0]  addr_mode,
  input  wire [15:0] addr_base,
  output reg  [15:0] eff_addr_q,
  // Visible state
  output reg  [7:0]  acc_q,
  output reg  [7:0]  x_q,
  output reg  [7:0]  y_q,
  output reg  [7:0]  stack_ptr_q,
  output reg  [15:0] pc_q,
  output reg  [7:0]  status_word_q,
  output reg         int_allowed_q
);

  localparam [1:0] S_RUN = 2'h0;
  localparam [1:0] S_LO  = 2'h1;
  localparam [1:0] S_HI  = 2'h2;
  localparam [1:0] S_END = 2'h3;

  reg  [1:0]  state_q;
  reg  [1:0]  state_d;
  reg  [15:0] vec_q;
  reg  [15:0] vec_d;
  reg  [7:0]  vec_lo_q;
  reg  [15:0] pc_d;
  reg  [7:0]  acc_d;
  reg  [7:0]  sw_d;
  reg  [7:0]  alu_res;
  reg         alu_c;
  reg         alu_h;
  reg         alu_v;
  reg  [8:0]  wide;
  reg  [4:0]  nib;
  reg  [7:0]  int_vec_lo;
  reg  [7:0]  idx_cur;
  reg  [7:0]  idx_d;
  reg  [8:0]  cmp;
  wire        irq_en = status_word_q[`SW_IRQ_EN];
  wire        cin    = status_word_q[`SW_CARRY];

  // Interrupt vector lookup by source code; unknown codes land on reset.
  always @* begin
    case (int_src)
      4'h0:    int_vec_lo = `VEC_ADC; // (RL19)
      4'h1:    int_vec_lo = `VEC_RC_WAKE;
      4'h2:    int_vec_lo = `VEC_INTERVAL;
      4'h3:    int_vec_lo = `VEC_WATCHDOG;
      4'h4:    int_vec_lo = `VEC_TIMER2;
      4'h5:    int_vec_lo = `VEC_TIMER1;
      4'h6:    int_vec_lo = `VEC_TIMER0;
      4'h7:    int_vec_lo = `VEC_EXT_TWO;
      4'h8:    int_vec_lo = `VEC_EXT_ONE;
      4'h9:    int_vec_lo = `VEC_KEY_SCAN;
      default: int_vec_lo = `VEC_RESET;
    endcase
  end

  // ALU: for add and subtract, carry, half carry and signed overflow come from the same sum; shifts and rotates take carry from the bit shifted out.
  always @* begin
    alu_res = alu_operand;
    alu_c   = cin;
    alu_h   = 1'b0;
    alu_v   = 1'b0;
    wide    = 9'h000;
    nib     = 5'h00;
    case (alu_op)
      `ALU_ADD: begin
        wide    = {1'b0, acc_q} + {1'b0, alu_operand} + {8'h00, cin};
        nib     = {1'b0, acc_q[3:0]} + {1'b0, alu_operand[3:0]} + {4'h0, cin};
        alu_res = wide[7:0];
        alu_c   = wide[8]; // (RL6)
        alu_h   = nib[4]; // (RL10)
        alu_v   = (acc_q[7] == alu_operand[7]) && (wide[7] != acc_q[7]); // (RL12)
      end
      `ALU_SUB: begin
        wide    = {1'b0, acc_q} - {1'b0, alu_operand} - {8'h00, ~cin};
        nib     = {1'b0, acc_q[3:0]} - {1'b0, alu_operand[3:0]} - {4'h0, ~cin};
        alu_res = wide[7:0];
        alu_c   = ~wide[8]; // (RL6)
        alu_h   = ~nib[4]; // (RL10)
        alu_v   = (acc_q[7] != alu_operand[7]) && (wide[7] != acc_q[7]); // (RL12)
      end
      `ALU_SHL: begin
        alu_res = {acc_q[6:0], 1'b0};
        alu_c   = acc_q[7]; // (RL6)
      end
      `ALU_ROL: begin
        alu_res = {acc_q[6:0], cin};
        alu_c   = acc_q[7];
      end
      `ALU_SHR: begin
        alu_res = {1'b0, acc_q[7:1]};
        alu_c   = acc_q[0];
      end
      `ALU_ROR: begin
        alu_res = {cin, acc_q[7:1]};
        alu_c   = acc_q[0];
      end
      default: alu_res = alu_operand;
    endcase
  end

  // Index unit: selected register, its next value and the compare difference.
  always @* begin
    idx_cur = idx_sel ? y_q : x_q;
    cmp     = {1'b0, idx_cur} - {1'b0, idx_din};
    case (idx_op)
      `IDX_LOAD:     idx_d = idx_din; // (RL5)
      `IDX_INC:      idx_d = idx_cur + 8'h01;
      `IDX_DEC:      idx_d = idx_cur - 8'h01;
      `IDX_FROM_ACC: idx_d = acc_q;
      default:       idx_d = idx_cur;
    endcase
  end

  // Status word next value. Clears are applied first so that a hardware set
  // in the same cycle wins over a software clear.
  always @* begin
    sw_d  = status_load ? status_din : status_word_q; // (RL21)
    acc_d = acc_q;
    if (clear_overflow_instr) begin
      sw_d[`SW_OVF]  = 1'b0; // (RL12)
      sw_d[`SW_HALF] = 1'b0; // (RL10)
    end
    if (clear_page_instr)
      sw_d[`SW_PAGE] = 1'b0; // (RL14)
    if (set_page_instr)
      sw_d[`SW_PAGE] = 1'b1;
    if (disable_interrupts_instr || int_accept)
      sw_d[`SW_IRQ_EN] = 1'b0; // (RL9)
    if (enable_interrupts_instr)
      sw_d[`SW_IRQ_EN] = 1'b1;
    if (software_break)
      sw_d[`SW_BREAK] = 1'b1; // (RL11)
    if (alu_op != `ALU_NONE) begin
      acc_d            = alu_res;
      sw_d[`SW_CARRY]  = alu_c;
      sw_d[`SW_ZERO]   = (alu_res == 8'h00); // (RL7)
      sw_d[`SW_NEG]    = alu_res[7]; // (RL13)
      sw_d[`SW_HALF]   = sw_d[`SW_HALF] | alu_h; // (RL10)
      sw_d[`SW_OVF]    = sw_d[`SW_OVF] | alu_v; // (RL12)
    end else if (acc_load) begin
      acc_d          = acc_din;
      sw_d[`SW_ZERO] = (acc_din == 8'h00); // (RL7)
      sw_d[`SW_NEG]  = acc_din[7];
    end
    if (idx_op == `IDX_CMP) begin
      sw_d[`SW_CARRY] = ~cmp[8];
      sw_d[`SW_ZERO]  = (cmp[7:0] == 8'h00);
      sw_d[`SW_NEG]   = cmp[7];
    end else if (idx_op != `IDX_NONE) begin
      sw_d[`SW_ZERO] = (idx_d == 8'h00);
      sw_d[`SW_NEG]  = idx_d[7];
    end
    if (bit_test) begin
      sw_d[`SW_ZERO] = ((acc_q & alu_operand) == 8'h00);
      sw_d[`SW_OVF]  = alu_operand[6]; // (RL12)
      sw_d[`SW_NEG]  = alu_operand[7]; // (RL13)
    end
  end

  // Vector fetch sequencing and the next program counter.
  always @* begin
    state_d = state_q;
    vec_d   = vec_q;
    pc_d    = pc_q;
    case (state_q)
      S_RUN: begin
        if (int_accept) begin
          vec_d   = `VEC_BASE | {8'h00, int_vec_lo}; // (RL19)
          state_d = S_LO;
        end else if (software_break) begin
          vec_d   = `TABLE_TOP; // (RL11)
          state_d = S_LO;
        end else if (table_call) begin
          vec_d   = `TABLE_TOP - {11'h000, table_index, 1'b0}; // (RL17)
          state_d = S_LO;
        end else if (page_call) begin
          pc_d = {`PAGE_CALL_HI, page_offset}; // (RL18)
        end else if (pc_load) begin
          pc_d = pc_din;
        end else if (pc_inc) begin
          pc_d = pc_q + 16'h0001;
        end
      end
      S_LO:    state_d = S_HI;
      S_HI:    state_d = S_END;
      S_END: begin
        pc_d    = {rom_data, vec_lo_q};
        state_d = S_RUN;
      end
      default: state_d = S_RUN;
    endcase
  end

  // Control registers with a defined reset state.
  always @(posedge clk) begin
    if (!nrst) begin
      state_q       <= S_LO;
      vec_q         <= `RESET_VEC; // (RL1)
      vec_lo_q      <= 8'h00;
      pc_q          <= 16'h0000;
      rom_addr_q    <= `RESET_VEC & `ROM_MASK;
      vec_busy_q    <= 1'b1;
      status_word_q <= `SW_RESET_VAL;
      int_allowed_q <= 1'b0;
      eff_addr_q    <= 16'h0000;
    end else begin
      state_q       <= state_d;
      vec_q         <= vec_d;
      pc_q          <= pc_d; // (RL1)
      status_word_q <= sw_d;
      vec_busy_q    <= (state_d != S_RUN);
      int_allowed_q <= irq_pending & irq_en; // (RL8)
      if (state_q == S_HI)
        vec_lo_q <= rom_data;
      // Program memory is only ever read; the top bits fold onto the 16K array.
      if (state_d == S_LO)
        rom_addr_q <= vec_d & `ROM_MASK; // (RL15)
      else if (state_d == S_HI)
        rom_addr_q <= (vec_q + 16'h0001) & `ROM_MASK;
      else
        rom_addr_q <= pc_d & `ROM_MASK; // (RL16)
      case (addr_mode)
        `AM_IDX_X: eff_addr_q <= addr_base + {8'h00, x_q}; // (RL5)
        `AM_IDX_Y: eff_addr_q <= addr_base + {8'h00, y_q};
        `AM_DIRECT: eff_addr_q <= {7'h00, status_word_q[`SW_PAGE], addr_base[7:0]}; // (RL14)
        default:   eff_addr_q <= addr_base;
      endcase
    end
  end

  // Data registers: software must initialise them, so reset leaves them alone.
  always @(posedge clk) begin
    if (pair_load) begin
      y_q   <= pair_din[15:8]; // (RL4)
      acc_q <= pair_din[7:0];
    end else begin
      acc_q <= acc_d;
      if (idx_op != `IDX_NONE && idx_op != `IDX_CMP && idx_sel)
        y_q <= idx_d;
    end
    if (idx_op != `IDX_NONE && idx_op != `IDX_CMP && !idx_sel)
      x_q <= idx_d; // (RL5)
  end

  // Stack pointer: undefined after reset by design; a call pushes two bytes,
  // an accepted interrupt or break pushes three (counter and status word).
  always @(posedge clk) begin
    if (stack_ptr_load)
      stack_ptr_q <= x_q; // (RL2)
    else if (nrst && state_q == S_RUN && (int_accept || software_break))
      stack_ptr_q <= stack_ptr_q - 8'h03; // (RL3)
    else if (call || table_call || page_call)
      stack_ptr_q <= stack_ptr_q - 8'h02; // (RL3)
    else if (ret_int)
      stack_ptr_q <= stack_ptr_q + 8'h03;
    else if (ret)
      stack_ptr_q <= stack_ptr_q + 8'h02;
  end

endmodule
`default_nettype wire

// file: core/cpu_state_defines.vh
// Constants for the programmer-visible core state and the program-memory map.
// Assumes a byte-wide program memory and a sequencer on the same clock.
`ifndef CPU_STATE_DEFINES_VH
`define CPU_STATE_DEFINES_VH

// Status word bit positions, top to bottom: N V G B H I Z C.
`define SW_CARRY      0
`define SW_ZERO       1
`define SW_IRQ_EN     2
`define SW_HALF       3
`define SW_BREAK      4
`define SW_PAGE       5
`define SW_OVF        6
`define SW_NEG        7
`define SW_RESET_VAL  8'h00

// Program memory map.
`define RESET_VEC     16'hFFFE
`define VEC_BASE      16'hFFE0
`define TABLE_TOP     16'hFFDE
`define PAGE_CALL_HI  8'hFF
`define ROM_MASK      16'h3FFF

// Interrupt vector low bytes, indexed by source code.
`define VEC_ADC       8'hE4
`define VEC_RC_WAKE   8'hE6
`define VEC_INTERVAL  8'hE8
`define VEC_WATCHDOG  8'hEA
`define VEC_TIMER2    8'hEE
`define VEC_TIMER1    8'hF0
`define VEC_TIMER0    8'hF2
`define VEC_EXT_TWO   8'hF6
`define VEC_EXT_ONE   8'hF8
`define VEC_KEY_SCAN  8'hFA
`define VEC_RESET     8'hFE

// Stack page sits at 100h to 17Fh.
`define STACK_PAGE    1'b1

// ALU operation codes.
`define ALU_NONE      3'h0
`define ALU_ADD       3'h1
`define ALU_SUB       3'h2
`define ALU_SHL       3'h3
`define ALU_ROL       3'h4
`define ALU_SHR       3'h5
`define ALU_ROR       3'h6
`define ALU_MOVE      3'h7

// Index operation codes.
`define IDX_NONE      3'h0
`define IDX_LOAD      3'h1
`define IDX_INC       3'h2
`define IDX_DEC       3'h3
`define IDX_CMP       3'h4
`define IDX_FROM_ACC  3'h5

// Address modes for the effective address unit.
`define AM_ABS        2'h0
`define AM_IDX_X      2'h1
`define AM_IDX_Y      2'h2
`define AM_DIRECT     2'h3

`endif

// file: test/cpu_state_asserts.sv
// Concurrent checks on the ports of cpu_state, bound from the bench top.
// Assumes one clock and the synchronous active-low reset nrst.
`include "cpu_state_defines.vh"
`timescale 1ns/1ps
`default_nettype none
module cpu_state_asserts (
  // Clock and reset
  input wire logic        clk,
  input wire logic        nrst,
  // Requests
  input wire logic        int_accept,
  input wire logic        software_break,
  input wire logic        table_call,
  input wire logic        page_call,
  input wire logic [7:0]  page_offset,
  input wire logic        enable_interrupts_instr,
  input wire logic        clear_overflow_instr,
  input wire logic [2:0]  alu_op,
  input wire logic        bit_test,
  input wire logic        status_load,
  // Observed state
  input wire logic        vec_busy_q,
  input wire logic [15:0] rom_addr_q,
  input wire logic [15:0] pc_q,
  input wire logic [7:0]  status_word_q,
  input wire logic        int_allowed_q
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // A flow request that neither a running vector fetch nor an accepted interrupt pre-empts.
  wire go = !vec_busy_q && !int_accept;
  wire vec_req = int_accept || software_break || table_call;

  property p_wrap; rom_addr_q[15:14] == 2'b00; endproperty
  a_wrap: assert property (p_wrap) else $error("fetch address beyond 16K");
  property p_irq_clr;
    int_accept && !vec_busy_q && !enable_interrupts_instr |=> !status_word_q[`SW_IRQ_EN];
  endproperty
  a_irq_clr: assert property (p_irq_clr) else $error("enable kept on service");
  property p_ei; enable_interrupts_instr && !status_load |=> status_word_q[`SW_IRQ_EN]; endproperty
  a_ei: assert property (p_ei) else $error("enable not set");
  property p_gate;
    !status_word_q[`SW_IRQ_EN] && $past(!status_word_q[`SW_IRQ_EN]) |-> !int_allowed_q;
  endproperty
  a_gate: assert property (p_gate) else $error("interrupt passed while disabled");
  property p_brk; software_break && go |=> status_word_q[`SW_BREAK]; endproperty
  a_brk: assert property (p_brk) else $error("break flag not set");
  property p_fetch; vec_req && !vec_busy_q |=> vec_busy_q [*3] ##1 !vec_busy_q; endproperty
  a_fetch: assert property (p_fetch) else $error("vector fetch length wrong");
  property p_vec_addr;
    int_accept && !vec_busy_q |=> rom_addr_q[15:8] == 8'h3F && !rom_addr_q[0]
      ##1 rom_addr_q == $past(rom_addr_q) + 16'h1;
  endproperty
  a_vec_addr: assert property (p_vec_addr) else $error("vector address wrong");
  property p_page;
    page_call && go && !software_break && !table_call |=> pc_q == {8'hFF, $past(page_offset)};
  endproperty
  a_page: assert property (p_page) else $error("page call target wrong");
  property p_clear_overflow_instr;
    clear_overflow_instr && alu_op == `ALU_NONE && !bit_test && !status_load
      |=> !status_word_q[`SW_OVF] && !status_word_q[`SW_HALF];
  endproperty
  a_clear_overflow_instr: assert property (p_clear_overflow_instr) else $error("overflow or half carry kept");
endmodule
`default_nettype wire

// file: test/cpu_state_tb.sv
// Self-checking bench for cpu_state; the bench drives every input itself.
// Assumes program memory answers one cycle after rom_addr_q changes.
`include "cpu_state_defines.vh"
`timescale 1ns/1ps
`default_nettype none
module cpu_state_tb;
  logic        clk, nrst, acc_load, pair_load, bit_test, status_load, stack_ptr_load;
  logic        enable_interrupts_instr, disable_interrupts_instr, clear_overflow_instr;
  logic        clear_page_instr, set_page_instr, pc_inc, pc_load, call, ret, ret_int;
  logic        table_call, page_call, software_break, irq_pending, int_accept, idx_sel;
  logic [7:0]  acc_din, idx_din, alu_operand, status_din, page_offset, rom_data;
  logic [15:0] pair_din, pc_din, addr_base;
  logic [2:0]  idx_op, alu_op;
  logic [3:0]  table_index, int_src;
  logic [1:0]  addr_mode;
  wire  [15:0] rom_addr_q, eff_addr_q, pc_q;
  wire  [7:0]  acc_q, x_q, y_q, stack_ptr_q, status_word_q;
  wire         vec_busy_q, int_allowed_q;
  int          mismatches, samples_checked, k;
  logic [7:0]  vec_lo [0:10];

  cpu_state i_cpu_state (.clk, .nrst, .rom_data, .rom_addr_q, .vec_busy_q, .acc_load, .acc_din,
    .pair_load, .pair_din, .idx_op, .idx_sel, .idx_din, .alu_op, .alu_operand, .bit_test,
    .enable_interrupts_instr, .disable_interrupts_instr, .clear_overflow_instr,
    .clear_page_instr, .set_page_instr, .status_load, .status_din, .pc_inc, .pc_load, .pc_din,
    .call, .ret, .ret_int, .stack_ptr_load, .table_call, .table_index, .page_call, .page_offset,
    .software_break, .irq_pending, .int_accept, .int_src, .addr_mode, .addr_base, .eff_addr_q,
    .acc_q, .x_q, .y_q, .stack_ptr_q, .pc_q, .status_word_q, .int_allowed_q);

  // Memory content is a cheap address hash, so each vector byte is distinct.
  function automatic logic [7:0] rom(input logic [15:0] a);
    rom = a[7:0] ^ 8'h5A;
  endfunction
  // Registered read: the byte for an address stands one cycle after it.
  always @(posedge clk) rom_data <= rom(rom_addr_q);

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Lets the edge take the request, then drops every pulse.
  task automatic fire;
    @(posedge clk);
    {acc_load, pair_load, bit_test, status_load, stack_ptr_load, pc_inc, pc_load} <= '0;
    {enable_interrupts_instr, disable_interrupts_instr, clear_overflow_instr} <= '0;
    {clear_page_instr, set_page_instr, call, ret, ret_int, table_call, page_call} <= '0;
    {software_break, int_accept, idx_op, alu_op} <= '0;
    #1;
  endtask

  // Bounded wait for the vector fetch, then the counter holds the fetched pair.
  task automatic wait_vec(input logic [15:0] v);
    for (k = 0; k < 8 && vec_busy_q !== 1'b0; k++) begin
      @(posedge clk);
      #1;
    end
    chk("vec_busy_q", vec_busy_q, 1'b0);
    chk("pc_q", pc_q, {rom(v + 16'h1), rom(v)});
  endtask

  task automatic summarize;
    if (mismatches == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // A hang counts against the run.
  initial begin
    #20000;
    mismatches++;
    summarize();
  end

  initial begin
    {nrst, acc_load, pair_load, bit_test, status_load, stack_ptr_load, pc_inc, pc_load} = '0;
    {enable_interrupts_instr, disable_interrupts_instr, clear_overflow_instr, ret_int} = '0;
    {clear_page_instr, set_page_instr, call, ret, table_call, page_call, idx_sel} = '0;
    {software_break, int_accept, irq_pending, idx_op, alu_op, table_index, int_src} = '0;
    {acc_din, idx_din, alu_operand, status_din, page_offset, pair_din, pc_din} = '0;
    {addr_base, addr_mode} = '0;
    vec_lo = '{8'hE4, 8'hE6, 8'hE8, 8'hEA, 8'hEE, 8'hF0, 8'hF2, 8'hF6, 8'hF8, 8'hFA, 8'hFE};
    repeat (3) @(posedge clk);
    #1 chk("status_word_q", status_word_q, 8'h00);
    @(posedge clk); nrst <= 1'b1;
    wait_vec(16'h3FFE);
    // Stack setup, then call and return move the pointer by two.
    @(posedge clk); idx_op <= `IDX_LOAD; idx_din <= 8'h7F; fire;
    @(posedge clk); stack_ptr_load <= 1'b1; addr_mode <= `AM_IDX_X; addr_base <= 16'h1000; fire;
    chk("stack_ptr_q", stack_ptr_q, 8'h7F);
    chk("eff_addr_q", eff_addr_q, 16'h107F);
    @(posedge clk); call <= 1'b1; idx_op <= `IDX_INC; fire;
    chk("stack_ptr_q", stack_ptr_q, 8'h7D);
    chk("x_q", x_q, 8'h80);
    @(posedge clk); ret <= 1'b1; fire;
    chk("stack_ptr_q", stack_ptr_q, 8'h7F);
    // Enable flag gates the pending request.
    @(posedge clk); irq_pending <= 1'b1; enable_interrupts_instr <= 1'b1; fire;
    @(posedge clk); #1 chk("int_allowed_q", int_allowed_q, 1'b1);
    @(posedge clk); disable_interrupts_instr <= 1'b1; fire;
    @(posedge clk); #1 chk("int_allowed_q", int_allowed_q, 1'b0);
    // Every interrupt source, including an unlisted code.
    for (int i = 0; i < 11; i++) begin
      @(posedge clk); enable_interrupts_instr <= 1'b1; fire;
      @(posedge clk); int_accept <= 1'b1; int_src <= 4'(i); fire;
      chk("irq_enable", status_word_q[`SW_IRQ_EN], 1'b0);
      chk("stack_ptr_q", stack_ptr_q, 8'h7C);
      wait_vec({8'h3F, vec_lo[i]});
      @(posedge clk); ret_int <= 1'b1; fire;
    end
    for (int n = 14; n < 16; n++) begin
      @(posedge clk); table_call <= 1'b1; table_index <= 4'(n); fire;
      wait_vec(16'h3FDE - 16'(2 * n));
      @(posedge clk); ret <= 1'b1; fire;
    end
    @(posedge clk); software_break <= 1'b1; fire;
    chk("break_flag", status_word_q[`SW_BREAK], 1'b1);
    wait_vec(16'h3FDE);
    @(posedge clk); page_call <= 1'b1; page_offset <= 8'h34; fire;
    chk("pc_q", pc_q, 16'hFF34);
    @(posedge clk); pc_load <= 1'b1; pc_din <= 16'h4005; fire;
    chk("rom_addr_q", rom_addr_q, 16'h0005);
    chk("pc_q", pc_q, 16'h4005);
    @(posedge clk); pc_inc <= 1'b1; fire;
    chk("rom_addr_q", rom_addr_q, 16'h0006);
    chk("pc_q", pc_q, 16'h4006);
    @(posedge clk); pc_load <= 1'b1; pc_din <= 16'hFFE2; fire;
    chk("rom_addr_q", rom_addr_q, 16'h3FE2);
    // Flag arithmetic from a known status word.
    @(posedge clk); status_load <= 1'b1; status_din <= 8'hFF; fire;
    chk("status_word_q", status_word_q, 8'hFF);
    @(posedge clk); status_load <= 1'b1; status_din <= 8'h00; fire;
    @(posedge clk); acc_load <= 1'b1; acc_din <= 8'h7F; fire;
    @(posedge clk); alu_op <= `ALU_ADD; alu_operand <= 8'h01; fire;
    chk("status_word_q", status_word_q, 8'hC8);
    @(posedge clk); acc_load <= 1'b1; acc_din <= 8'h00; fire;
    chk("status_word_q", status_word_q, 8'h4A);
    @(posedge clk); clear_overflow_instr <= 1'b1; fire;
    chk("status_word_q", status_word_q, 8'h02);
    @(posedge clk); acc_load <= 1'b1; acc_din <= 8'hFF; fire;
    @(posedge clk); alu_op <= `ALU_ADD; alu_operand <= 8'h01; fire;
    chk("status_word_q", status_word_q, 8'h0B);
    @(posedge clk); alu_op <= `ALU_ROL; fire;
    chk("acc_q", acc_q, 8'h01);
    chk("carry", status_word_q[`SW_CARRY], 1'b0);
    @(posedge clk); bit_test <= 1'b1; alu_operand <= 8'hC0; fire;
    chk("nvz", {status_word_q[7:6], status_word_q[`SW_ZERO]}, 3'b111);
    // Subtract with carry as no-borrow, a shift, then index transfer and compare.
    @(posedge clk); status_load <= 1'b1; status_din <= 8'h01; fire;
    @(posedge clk); acc_load <= 1'b1; acc_din <= 8'h50; fire;
    @(posedge clk); alu_op <= `ALU_SUB; alu_operand <= 8'hB0; fire;
    chk("status_word_q", status_word_q, 8'hC8);
    chk("acc_q", acc_q, 8'hA0);
    @(posedge clk); alu_op <= `ALU_SHL; fire;
    chk("carry", status_word_q[`SW_CARRY], 1'b1);
    @(posedge clk); idx_sel <= 1'b1; idx_op <= `IDX_FROM_ACC; fire;
    chk("y_q", y_q, 8'h40);
    @(posedge clk); idx_op <= `IDX_CMP; idx_din <= 8'h40; fire;
    chk("nzc", {status_word_q[7], status_word_q[1:0]}, 3'b011);
    @(posedge clk); idx_op <= `IDX_DEC; fire;
    @(posedge clk); addr_mode <= `AM_IDX_Y; addr_base <= 16'h2000; fire;
    chk("eff_addr_q", eff_addr_q, 16'h203F);
    // Direct page follows the page flag.
    @(posedge clk); set_page_instr <= 1'b1; fire;
    @(posedge clk); addr_mode <= `AM_DIRECT; addr_base <= 16'h0042; fire;
    chk("eff_addr_q", eff_addr_q, 16'h0142);
    @(posedge clk); clear_page_instr <= 1'b1; fire;
    @(posedge clk); #1 chk("eff_addr_q", eff_addr_q, 16'h0042);
    // Reset in mid-run: flags clear, the stack pointer keeps its value.
    @(posedge clk); nrst <= 1'b0; fire;
    chk("status_word_q", status_word_q, 8'h00);
    chk("stack_ptr_q", stack_ptr_q, 8'h7A);
    @(posedge clk); nrst <= 1'b1;
    wait_vec(16'h3FFE);
    @(posedge clk); pair_load <= 1'b1; pair_din <= 16'h1234; fire;
    chk("pair", {y_q, acc_q}, 16'h1234);
    summarize();
  end
endmodule

bind cpu_state cpu_state_asserts i_cpu_state_asserts (.clk, .nrst, .int_accept, .software_break,
  .table_call, .page_call, .page_offset, .enable_interrupts_instr, .clear_overflow_instr,
  .alu_op, .bit_test, .status_load, .vec_busy_q, .rom_addr_q, .pc_q, .status_word_q,
  .int_allowed_q);
`default_nettype wire
